// ---- include/pcs_pkg.sv ----
package pcs_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_STAGES = 8;
   localparam int NUM_GROUPS = 4;
   localparam int SIG_W      = 32;
   localparam int NUM_SIGS   = 64;            // Selectable supervised signals
   localparam int NUM_VAI    = 5;             // Network-supplied virtual inputs
   localparam int MEAS_SIGS  = NUM_SIGS - NUM_VAI;
   localparam int DLY_W      = 16;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
   localparam logic [6:0] IV_10_MS  = 7'h0A;
   localparam logic [6:0] IV_20_MS  = 7'h14;
   localparam logic [6:0] IV_100_MS = 7'h64;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_GROUP     = 12'h000;
   localparam logic [11:0] OFF_STATUS    = 12'h004;
   localparam logic [11:0] OFF_IRQ_STAT  = 12'h008;
   localparam logic [11:0] OFF_IRQ_MASK  = 12'h00C;
   localparam logic [11:0] OFF_STAGE     = 12'h800; // + stage*80h + group*20h + word*4
   localparam logic [2:0]  W_CFG         = 3'h0;
   localparam logic [2:0]  W_LIMIT       = 3'h1;
   localparam logic [2:0]  W_HYST        = 3'h2;
   localparam logic [2:0]  W_FLOOR       = 3'h3;
   localparam logic [2:0]  W_DELAY       = 3'h4;

   // Config word fields
   localparam int CFG_EN_POS    = 0;
   localparam int CFG_MODE_POS  = 1;
   localparam int CFG_IV_POS    = 3;
   localparam int CFG_SRCA_POS  = 5;
   localparam int CFG_SRCB_POS  = 11;

   // Reset values
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [1:0]  RST_GROUP = 2'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PCS_OVER    = 2'h0,
      PCS_UNDER   = 2'h1,
      PCS_DIFF    = 2'h2,
      PCS_MAGNITUDE_DIFFERENCE_MODE = 2'h3
   } pcs_mode_t;

   typedef struct packed {
      logic              en;
      pcs_mode_t         mode;
      logic [1:0]        iv;
      logic [5:0]        src_a;
      logic [5:0]        src_b;
      logic [SIG_W-1:0]  limit;
      logic [SIG_W-1:0]  hyst;
      logic [SIG_W-1:0]  under_mode_floor;
      logic [DLY_W-1:0]  delay_ms;
   } pcs_stage_cfg_t;

endpackage

// ---- test/pcs_meas_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Measurement source model
// ----------------------------------------------------------------
module pcs_meas_model (
   output logic [pcs_pkg::MEAS_SIGS-1:0][pcs_pkg::SIG_W-1:0] meas_o,
   output logic [pcs_pkg::NUM_VAI-1:0][pcs_pkg::SIG_W-1:0]   vai_o
);
   logic [pcs_pkg::SIG_W-1:0] sig [pcs_pkg::NUM_SIGS];

   // All sources idle at zero
   initial begin
      for (int i = 0; i < pcs_pkg::NUM_SIGS; i++) begin
         sig[i] = 32'h0;
      end
   end

   // One source update; caller runs just after a clock edge
   task automatic set_sig(input int idx, input logic [31:0] val);
      sig[idx] <= val;
   endtask

   always_comb begin
      for (int i = 0; i < pcs_pkg::MEAS_SIGS; i++) meas_o[i] = sig[i];
      for (int i = 0; i < pcs_pkg::NUM_VAI; i++) vai_o[i] = sig[pcs_pkg::MEAS_SIGS + i];
   end
endmodule // pcs_meas_model

// ---- test/pcs_stages_chk.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus and stage output checks
// ----------------------------------------------------------------
module pcs_stages_chk #(
   parameter int MS_CYCLES = 10
) (
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  start_o,
   input wire logic [7:0]  trip_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   logic setup;
   logic unmapped;

   // Setup phase and address decode
   assign setup    = psel && !penable;
   assign unmapped = ((paddr < 12'h010) && (paddr[1:0] != 2'h0)) ||
                     ((paddr >= 12'h010) && ((paddr < 12'h800) || (paddr >= 12'hC00)));

   AST_READY_AFTER_SETUP:
      assert property (setup |=> pready) else $error("no ready after setup");
   AST_READY_ONE_CYCLE:
      assert property (pready |=> !pready) else $error("ready held too long");
   AST_READY_CAUSE:
      assert property (pready |-> $past(setup)) else $error("ready without setup");
   AST_ERR_WITH_READY:
      assert property (pslverr |-> pready) else $error("error without ready");
   AST_ERR_DECODE:
      assert property (setup |=> pslverr == $past(unmapped)) else $error("bad error decode");
   AST_RDATA_IDLE:
      assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
   AST_TRIP_WITH_START:
      assert property ((trip_o & ~start_o) == 8'h00) else $error("trip without start");
   AST_TRIP_LATER:
      assert property ((trip_o & ~$past(start_o)) == 8'h00) else $error("trip not delayed");
endmodule // pcs_stages_chk

bind pcs_stages pcs_stages_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_o(start_o), .trip_o(trip_o)
);

// ---- test/programmable_compare_stages_tb.sv ----
`timescale 1ns/1ps
module programmable_compare_stages_tb;
   logic        mclk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, irq_o, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  start_o, trip_o;
   logic [pcs_pkg::MEAS_SIGS-1:0][pcs_pkg::SIG_W-1:0] meas;
   logic [pcs_pkg::NUM_VAI-1:0][pcs_pkg::SIG_W-1:0]   vai;
   int          n_fail, checks, cyc, n;
   typedef struct {logic [1:0] m, iv; logic [31:0] a, b, lim, flr; logic e;} pcs_row_t;
   // One row per stage: mode, interval, source A, source B, limit, floor, expected start
   pcs_row_t rows [8] = '{
      '{2'h0, 2'h0, 32'h65, 32'h0, 32'h64, 32'h0, 1'h1},
      '{2'h0, 2'h0, 32'h64, 32'h0, 32'h64, 32'h0, 1'h0},
      '{2'h1, 2'h0, 32'h32, 32'h0, 32'h64, 32'h14, 1'h1},
      '{2'h1, 2'h0, 32'hA, 32'h0, 32'h64, 32'h14, 1'h0},
      '{2'h2, 2'h1, 32'h1E, 32'hA, 32'h13, 32'h0, 1'h1},
      '{2'h2, 2'h0, 32'hA, 32'h1E, 32'hFFFF_FFE2, 32'h0, 1'h0},
      '{2'h3, 2'h1, 32'hA, 32'h1E, 32'h13, 32'h0, 1'h1},
      '{2'h0, 2'h0, 32'h96, 32'h1F4, 32'h64, 32'h0, 1'h1}};

   pcs_stages #(.MS_CYCLES(10)) uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .meas_i(meas), .virtual_analog_input_i(vai),
      .start_o(start_o), .trip_o(trip_o), .irq_o(irq_o));
   pcs_meas_model u_meas (.meas_o(meas), .vai_o(vai));

   // Clock
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   function automatic logic [11:0] sa(input int s, input int w);
      return 12'h800 + 12'(s * 128 + w * 4);
   endfunction

   function automatic logic [31:0] cfg(input logic [1:0] m, input logic [1:0] iv,
                                       input int a, input int b);
      return 32'h1 | (32'(m) << 1) | (32'(iv) << 3) | (32'(a) << 5) | (32'(b) << 11);
   endfunction

   // One APB transfer, held until ready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      if (n_fail == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {n_fail, checks, cyc} = '0;
      rst_n_i = 1'b0;
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      cmp({15'h0, irq_o, trip_o, start_o}, 32'h0);
      apb(1'b0, pcs_pkg::OFF_GROUP, 32'h0);
      cmp(rd, 32'h0);
      apb(1'b0, pcs_pkg::OFF_IRQ_MASK, 32'h0);
      cmp(rd, 32'h0);
      apb(1'b0, sa(3, 1), 32'h0);
      cmp(rd, pcs_pkg::RST_WORD);
      apb(1'b1, 12'h010, 32'hFFFF);
      cmp({31'h0, err}, 32'h1);
      apb(1'b0, 12'hC00, 32'h0);
      cmp({err, rd[30:0]}, 32'h8000_0000);
      // Table rows: all eight stages at once
      for (int s = 0; s < 8; s++) begin
         u_meas.set_sig(s == 7 ? 59 : 2 * s, rows[s].a);
         u_meas.set_sig(2 * s + 1, rows[s].b);
         apb(1'b1, sa(s, 1), rows[s].lim);
         apb(1'b1, sa(s, 3), rows[s].flr);
         apb(1'b1, sa(s, 4), 32'hFFFF);
         apb(1'b1, sa(s, 0), cfg(rows[s].m, rows[s].iv, s == 7 ? 59 : 2 * s, 2 * s + 1));
      end
      repeat (250) @(posedge mclk_i);
      for (int s = 0; s < 8; s++) begin
         cmp({31'h0, start_o[s]}, {31'h0, rows[s].e});
      end
      cmp({24'h0, start_o}, 32'hD5);
      cmp({24'h0, trip_o}, 32'h0);
      apb(1'b0, pcs_pkg::OFF_STATUS, 32'h0);
      cmp(rd, 32'hD5);
      apb(1'b0, pcs_pkg::OFF_IRQ_STAT, 32'h0);
      cmp({irq_o, rd[30:0]}, 32'hD5);
      apb(1'b1, pcs_pkg::OFF_IRQ_MASK, 32'h1);
      repeat (3) @(posedge mclk_i);
      cmp({31'h0, irq_o}, 32'h1);
      apb(1'b1, pcs_pkg::OFF_IRQ_STAT, 32'hFFFF);
      repeat (3) @(posedge mclk_i);
      cmp({31'h0, irq_o}, 32'h0);
      apb(1'b0, pcs_pkg::OFF_IRQ_STAT, 32'h0);
      cmp(rd, 32'h0);
      // Dead band on stage 0
      apb(1'b1, sa(0, 2), 32'hA);
      u_meas.set_sig(0, 32'h5F);
      repeat (250) @(posedge mclk_i);
      cmp({31'h0, start_o[0]}, 32'h1);
      u_meas.set_sig(0, 32'h55);
      repeat (250) @(posedge mclk_i);
      cmp({31'h0, start_o[0]}, 32'h0);
      // Operate delay of 3 ms
      apb(1'b1, sa(0, 4), 32'h3);
      u_meas.set_sig(0, 32'hC8);
      for (n = 0; start_o[0] !== 1'b1 && n < 300; n++) @(posedge mclk_i);
      for (n = 0; trip_o[0] !== 1'b1 && n < 60; n++) @(posedge mclk_i);
      cmp({31'h0, n >= 30 && n <= 40}, 32'h1);
      apb(1'b0, pcs_pkg::OFF_IRQ_STAT, 32'h0);
      cmp(rd, 32'h101);
      // Trip drops together with start
      u_meas.set_sig(0, 32'h0);
      for (n = 0; start_o[0] !== 1'b0 && n < 300; n++) @(posedge mclk_i);
      cmp({31'h0, trip_o[0]}, 32'h0);
      u_meas.set_sig(0, 32'hC8);
      repeat (250) @(posedge mclk_i);
      cmp({30'h0, trip_o[0], start_o[0]}, 32'h3);
      apb(1'b1, sa(0, 0), 32'h0);
      repeat (3) @(posedge mclk_i);
      cmp({30'h0, trip_o[0], start_o[0]}, 32'h0);
      // Setting group switch
      apb(1'b1, pcs_pkg::OFF_GROUP, 32'h1);
      repeat (3) @(posedge mclk_i);
      cmp({24'h0, start_o}, 32'h0);
      apb(1'b0, pcs_pkg::OFF_GROUP, 32'h0);
      cmp(rd, 32'h1);
      apb(1'b1, pcs_pkg::OFF_GROUP, 32'h0);
      repeat (250) @(posedge mclk_i);
      cmp({24'h0, start_o}, 32'hD4);
      // Reset in mid-run
      rst_n_i <= 1'b0;
      @(posedge mclk_i);
      cmp({15'h0, irq_o, trip_o, start_o}, 32'h0);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      apb(1'b0, sa(0, 1), 32'h0);
      cmp(rd, pcs_pkg::RST_WORD);
      apb(1'b0, pcs_pkg::OFF_IRQ_MASK, 32'h0);
      cmp(rd, 32'h0);
      tally_and_finish();
   end
endmodule // programmable_compare_stages_tb

// ---- verilog/pcs_stages.sv ----
`timescale 1ns/1ps
// What this block does
// - Eight independent stages, each with own settings and own outputs.
// - Per-stage enable; disabled stage never shows start or trip.
// - Modes over, under, signed difference and magnitude difference.
// - Magnitude mode: |A - B| greater than limit activates.
// - Signed mode: A - B positive and greater than limit activates.
// - Source B used only in difference modes; over/under use A only.
// - Under mode: value below floor is never a fault.
// - Trip follows start after a fixed settable operate delay.
// - Dead band around limit keeps output from chattering.
// - Four setting groups; stages use the active group.
// - Limit is in the selected signal's own units and scale.
// - Sources cover all measured quantities plus five virtual inputs.
module pcs_stages #(
   parameter int MS_CYCLES = pcs_pkg::MS_CYCLES
) (
   input  wire logic                                         mclk_i,
   input  wire logic                                         rst_n_i,
   input  wire logic                                         psel,
   input  wire logic                                         penable,
   input  wire logic                                         pwrite,
   input  wire logic [11:0]                                  paddr,
   input  wire logic [31:0]                                  pwdata,
   output logic      [31:0]                                  prdata,
   output logic                                              pready,
   output logic                                              pslverr,
   input  wire logic [pcs_pkg::MEAS_SIGS-1:0][pcs_pkg::SIG_W-1:0] meas_i,
   input  wire logic [pcs_pkg::NUM_VAI-1:0][pcs_pkg::SIG_W-1:0]   virtual_analog_input_i,
   output logic      [pcs_pkg::NUM_STAGES-1:0]               start_o,
   output logic      [pcs_pkg::NUM_STAGES-1:0]               trip_o,
   output logic                                              irq_o
);

   // ----------------------------------------------------------------
   // Compare function
   // ----------------------------------------------------------------
   function automatic logic stage_hit(input pcs_pkg::pcs_mode_t mode,
                                      input logic [31:0] a, input logic [31:0] b,
                                      input logic [31:0] lim, input logic [31:0] hyst,
                                      input logic [31:0] flr, input logic active);
      logic signed [33:0] sa;
      logic signed [33:0] sb;
      logic signed [33:0] d;
      logic signed [33:0] thr;
      logic               hit;
      sa  = 34'(signed'(a));
      sb  = 34'(signed'(b));
      d   = sa;
      hit = 1'b0;
      case (mode)
         pcs_pkg::PCS_UNDER: begin
            thr = active ? 34'(signed'(lim)) + 34'(signed'(hyst)) : 34'(signed'(lim));
            hit = (sa >= 34'(signed'(flr))) && (sa < thr);
         end
         pcs_pkg::PCS_DIFF: begin
            d   = sa - sb;
            thr = active ? 34'(signed'(lim)) - 34'(signed'(hyst)) : 34'(signed'(lim));
            hit = (d > 34'sh0) && (d > thr);
         end
         pcs_pkg::PCS_MAGNITUDE_DIFFERENCE_MODE: begin
            d   = sa - sb;
            d   = (d < 34'sh0) ? -d : d;
            thr = active ? 34'(signed'(lim)) - 34'(signed'(hyst)) : 34'(signed'(lim));
            hit = d > thr;
         end
         default: begin
            thr = active ? 34'(signed'(lim)) - 34'(signed'(hyst)) : 34'(signed'(lim));
            hit = d > thr;
         end
      endcase
      return hit;
   endfunction

   // ----------------------------------------------------------------
   // Setting storage
   // ----------------------------------------------------------------
   logic [31:0] cfg_mem [0:255];     // {stage, group, word}
   logic [1:0]  act_group;
   logic [15:0] irq_stat;            // [7:0] start rise, [15:8] trip rise
   logic [15:0] irq_mask;
   logic [pcs_pkg::NUM_STAGES-1:0] start_q;
   logic [pcs_pkg::NUM_STAGES-1:0] trip_q;

   logic setup_ph;
   logic wr_en;
   logic in_stage_rng;
   assign setup_ph     = psel & ~penable;
   assign wr_en        = psel & penable & pready & pwrite;
   assign in_stage_rng = (paddr[11:10] == pcs_pkg::OFF_STAGE[11:10]);

   // Setting words written by software
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 256; i++) begin
            cfg_mem[i] <= pcs_pkg::RST_WORD;
         end
      end else if (wr_en && in_stage_rng) begin
         cfg_mem[paddr[9:2]] <= pwdata;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act_group <= pcs_pkg::RST_GROUP;
      end else if (wr_en && paddr == pcs_pkg::OFF_GROUP) begin
         act_group <= pwdata[1:0];
      end
   end

   // Interrupt mask
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_mask <= 16'h0000;
      end else if (wr_en && paddr == pcs_pkg::OFF_IRQ_MASK) begin
         irq_mask <= pwdata[15:0];
      end
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   logic        addr_ok;
   always_comb begin
      rd_mux  = 32'h0000_0000;
      addr_ok = 1'b1;
      if (in_stage_rng) begin
         rd_mux = cfg_mem[paddr[9:2]];
      end else begin
         case (paddr)
            pcs_pkg::OFF_GROUP:    rd_mux = {30'h0, act_group};
            pcs_pkg::OFF_STATUS:   rd_mux = {16'h0, trip_q, start_q};
            pcs_pkg::OFF_IRQ_STAT: rd_mux = {16'h0, irq_stat};
            pcs_pkg::OFF_IRQ_MASK: rd_mux = {16'h0, irq_mask};
            default:               addr_ok = 1'b0;
         endcase
      end
   end

   // One wait-free answer in the first access cycle
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup_ph;
         pslverr <= setup_ph & ~addr_ok;
         prdata  <= (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Time base
   // ----------------------------------------------------------------
   logic [31:0] ms_div;
   logic        ms_tick;
   logic [6:0]  iv_cnt [0:2];
   logic [2:0]  iv_tick;
   logic [6:0]  iv_len [0:2];
   assign iv_len[0] = pcs_pkg::IV_10_MS;
   assign iv_len[1] = pcs_pkg::IV_20_MS;
   assign iv_len[2] = pcs_pkg::IV_100_MS;
   assign ms_tick   = (ms_div == 32'(MS_CYCLES - 1));

   // Millisecond prescaler
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ms_div <= 32'h0000_0000;
      end else begin
         ms_div <= ms_tick ? 32'h0000_0000 : ms_div + 32'h0000_0001;
      end
   end

   // Evaluation interval ticks
   for (genvar k = 0; k < 3; k++) begin : g_iv
      assign iv_tick[k] = ms_tick && (iv_cnt[k] == iv_len[k] - 7'h01);
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            iv_cnt[k] <= 7'h00;
         end else if (ms_tick) begin
            iv_cnt[k] <= iv_tick[k] ? 7'h00 : iv_cnt[k] + 7'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Stages
   // ----------------------------------------------------------------
   logic [pcs_pkg::NUM_SIGS-1:0][pcs_pkg::SIG_W-1:0] src;
   assign src = {virtual_analog_input_i, meas_i};

   logic [pcs_pkg::NUM_STAGES-1:0] start_rise;
   logic [pcs_pkg::NUM_STAGES-1:0] trip_rise;

   for (genvar s = 0; s < pcs_pkg::NUM_STAGES; s++) begin : g_stage
      pcs_pkg::pcs_stage_cfg_t cfg;
      logic [7:0]               base;
      logic [31:0]              cw;
      logic [31:0]              val_b;
      logic                     eval;
      logic                     hit;
      logic [pcs_pkg::DLY_W-1:0] dly_cnt;

      assign base = {3'(s), act_group, 3'h0};
      assign cw   = cfg_mem[base | {5'h00, pcs_pkg::W_CFG}];
      assign cfg.en               = cw[pcs_pkg::CFG_EN_POS];
      assign cfg.mode             = pcs_pkg::pcs_mode_t'(cw[pcs_pkg::CFG_MODE_POS +: 2]);
      assign cfg.iv               = cw[pcs_pkg::CFG_IV_POS +: 2];
      assign cfg.src_a            = cw[pcs_pkg::CFG_SRCA_POS +: 6];
      assign cfg.src_b            = cw[pcs_pkg::CFG_SRCB_POS +: 6];
      assign cfg.limit            = cfg_mem[base | {5'h00, pcs_pkg::W_LIMIT}];
      assign cfg.hyst             = cfg_mem[base | {5'h00, pcs_pkg::W_HYST}];
      assign cfg.under_mode_floor = cfg_mem[base | {5'h00, pcs_pkg::W_FLOOR}];
      assign cfg.delay_ms         = cfg_mem[base | {5'h00, pcs_pkg::W_DELAY}][pcs_pkg::DLY_W-1:0];

      assign val_b = cfg.mode[1] ? src[cfg.src_b] : 32'h0000_0000;

      assign eval = (cfg.iv == 2'h0) ? iv_tick[0] :
                    (cfg.iv == 2'h1) ? iv_tick[1] : iv_tick[2];

      assign hit = stage_hit(cfg.mode, src[cfg.src_a], val_b, cfg.limit, cfg.hyst,
                             cfg.under_mode_floor, start_q[s]);

      always_ff @(posedge mclk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            start_q[s] <= 1'b0;
         end else if (!cfg.en) begin
            start_q[s] <= 1'b0;
         end else if (eval) begin
            start_q[s] <= hit;
         end
      end

      always_ff @(posedge mclk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            dly_cnt   <= '0;
            trip_q[s] <= 1'b0;
         end else if (!cfg.en || !start_q[s] || (eval && !hit)) begin
            dly_cnt   <= '0;
            trip_q[s] <= 1'b0;
         end else begin
            if (ms_tick && dly_cnt < cfg.delay_ms) begin
               dly_cnt <= dly_cnt + 1'b1;
            end
            trip_q[s] <= (dly_cnt >= cfg.delay_ms);
         end
      end
   end

   // ----------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------
   logic [pcs_pkg::NUM_STAGES-1:0] start_d;
   logic [pcs_pkg::NUM_STAGES-1:0] trip_d;
   logic [15:0]                    irq_set;
   logic [15:0]                    irq_clr;
   assign start_rise = start_q & ~start_d;
   assign trip_rise  = trip_q & ~trip_d;
   assign irq_set    = {trip_rise, start_rise};
   assign irq_clr    = (wr_en && paddr == pcs_pkg::OFF_IRQ_STAT) ? pwdata[15:0] : 16'h0000;

   // Sticky status, set beats clear
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_d  <= '0;
         trip_d   <= '0;
         irq_stat <= 16'h0000;
      end else begin
         start_d  <= start_q;
         trip_d   <= trip_q;
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      end
   end

   // Registered outputs
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_o <= '0;
         trip_o  <= '0;
         irq_o   <= 1'b0;
      end else begin
         start_o <= start_q;
         trip_o  <= trip_q;
         irq_o   <= |(irq_stat & irq_mask);
      end
   end

endmodule // pcs_stages
